//--- src/eep_pkg.sv
// Shared constants, types and decode helpers for the EEPROM program/erase controller.
package eep_pkg;
	// Register byte offsets on the bus.
	localparam logic [11:0] OFF_PCTL = 12'h000;
	localparam logic [11:0] OFF_BLOCK_PROTECT_REGISTER = 12'h004;
	localparam logic [11:0] OFF_SETUP = 12'h008;
	localparam logic [11:0] OFF_STAT = 12'h00C;
	// The array occupies 0x800-0xFFF, one byte per aligned word.
	localparam int ARRAY_SEL_BIT = 11;
	// Program control register field positions and reset value.
	localparam int PC_HV = 0;
	localparam int PC_LAT = 1;
	localparam int PC_ERASE = 2;
	localparam int PC_ROW = 3;
	localparam int PC_BYTE = 4;
	localparam logic [4:0] PCTL_RST = 5'h00;
	// Block protect register field positions and reset value.
	localparam int BP_SETUP = 4;
	localparam logic [4:0] BLOCK_PROTECT_REGISTER_RST = 5'h1F;
	localparam logic [6:0] BLOCK_PROTECT_REGISTER_WINDOW = 7'h40;
	// Setup register fields; bits 1 and 3 always read as one.
	localparam int SU_MAP = 0;
	localparam logic [7:0] SETUP_FIXED = 8'h0A;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam int ARRAY_BYTES = 512;
	// First index of protect blocks 1, 2 and 3.
	localparam logic [8:0] BLK1_BASE = 9'h020;
	localparam logic [8:0] BLK2_BASE = 9'h060;
	localparam logic [8:0] BLK3_BASE = 9'h0E0;

	typedef enum logic [1:0] {
		MODE_BOOT = 2'b00,
		MODE_SINGLE = 2'b01,
		MODE_TEST = 2'b10,
		MODE_EXP = 2'b11
	} eep_mode_t;

	typedef enum logic [1:0] {
		OP_PROG = 2'b00,
		OP_BYTE = 2'b01,
		OP_ROW = 2'b10,
		OP_BULK = 2'b11
	} eep_op_t;

	function automatic logic [1:0] eep_block_of(input logic [8:0] idx);
		if (idx >= BLK3_BASE)
			return 2'd3;
		else if (idx >= BLK2_BASE)
			return 2'd2;
		else if (idx >= BLK1_BASE)
			return 2'd1;
		return 2'd0;
	endfunction

	function automatic eep_op_t eep_kind_of(input logic [4:0] pctl);
		if (!pctl[PC_ERASE])
			return OP_PROG;
		else if (pctl[PC_BYTE])
			return OP_BYTE;
		else if (pctl[PC_ROW])
			return OP_ROW;
		return OP_BULK;
	endfunction
endpackage

//--- src/eep_array.sv
// Nonvolatile 512-byte array with program, byte, row and bulk erase actions.
`timescale 1ns/10ps
`default_nettype none
module eep_array
	import eep_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Read port
	input wire logic [8:0] rd_idx,
	output logic [7:0] rd_data,
	// Action request
	input wire logic op_go,
	input wire eep_op_t op_kind,
	input wire logic [8:0] tgt_idx,
	input wire logic [7:0] tgt_data,
	input wire logic [3:0] prot
);
	// Contents are nonvolatile, so reset leaves them alone.
	logic [7:0] mem [ARRAY_BYTES];
	logic chk_ff;
	logic [8:0] chk_idx_ff;
	logic [7:0] chk_val_ff;

	assign rd_data = mem[rd_idx];

	always_ff @(posedge clk)
	begin
		for (int i = 0; i < ARRAY_BYTES; i++)
		begin
			if (op_go && !prot[eep_block_of(9'(i))])
			begin
				unique case (op_kind)
					OP_PROG: if (9'(i) == tgt_idx) mem[i] <= mem[i] & tgt_data;
					OP_BYTE: if (9'(i) == tgt_idx) mem[i] <= ERASED_BYTE;
					OP_ROW: if (9'(i) >> 4 == tgt_idx >> 4) mem[i] <= ERASED_BYTE;
					OP_BULK: mem[i] <= ERASED_BYTE;
				endcase
			end
		end
	end

	always_ff @(posedge clk)
	begin
		chk_ff <= op_go && op_kind != OP_BULK && prot[eep_block_of(tgt_idx)];
		chk_idx_ff <= tgt_idx;
		chk_val_ff <= mem[tgt_idx];
	end

	property p_protected_kept;
		@(posedge clk) disable iff (rst) chk_ff |-> mem[chk_idx_ff] == chk_val_ff;
	endproperty
	a_protected_kept: assert property (p_protected_kept) else $error("protected byte changed");
endmodule
`default_nettype wire

//--- src/eep_protect.sv
// Block protect register with the one-time clear window after reset.
`timescale 1ns/10ps
`default_nettype none
module eep_protect
	import eep_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic special_mode,
	input wire logic wr_en,
	input wire logic [4:0] wdata,
	output logic [4:0] block_protect_register_ff
);
	logic [6:0] win_cnt_ff;
	logic used_ff;
	logic may_clear;

	assign may_clear = special_mode || (win_cnt_ff < BLOCK_PROTECT_REGISTER_WINDOW && !used_ff);

	always_ff @(posedge clk)
	begin
		if (rst)
			win_cnt_ff <= 7'h00;
		else if (win_cnt_ff < BLOCK_PROTECT_REGISTER_WINDOW)
			win_cnt_ff <= win_cnt_ff + 7'h01;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			block_protect_register_ff <= BLOCK_PROTECT_REGISTER_RST;
			used_ff <= 1'b0;
		end
		else if (wr_en)
		begin
			block_protect_register_ff <= may_clear ? wdata : (block_protect_register_ff | wdata);
			used_ff <= 1'b1;
		end
	end

	property p_block_protect_register_locked;
		@(posedge clk) disable iff (rst)
			(wr_en && !special_mode && used_ff) |=> ((block_protect_register_ff & $past(block_protect_register_ff)) == $past(block_protect_register_ff));
	endproperty
	a_block_protect_register_locked: assert property (p_block_protect_register_locked) else $error("protect bit cleared outside window");
endmodule
`default_nettype wire

//--- src/eep_top.sv
// EEPROM program/erase controller with setup register, AHB-Lite register slave.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Setup register bit 1 always reads one; writes to it are ignored.
// - Single-chip and bootstrap modes force the map enable to one.
// - Test mode forces map enable to zero; expanded mode follows stored bit.
// - With map enable zero the array does not answer; with one it is decoded.
// - Program and erase only touch regions whose protect bits are clear.
// - Row erase: one write anywhere in an aligned row latches the whole row.
// - Bulk erase selects whole array; targeting setup also erases setup.
// - Then software clears the control register; reads return to normal.
// - Control bits: voltage 0, latch 1, erase 2, row 3, byte 4.
// - Row erase setup is 0x0E, 0x0F applies voltage; the row is erased when the voltage bit is cleared.
// - Byte erase: a write to an address latches exactly that byte.
// - Setup register takes byte program and erase in any mode if unprotected.
// - New setup value takes effect only after the next reset.
// - Select bits: both zero bulk, row only 16-byte row, byte set byte.
// - Protect bits clear once within 64 cycles in normal modes, anytime special.
// - Latch bit zero serves reads; one captures array writes as targets.
module eep_top
	import eep_pkg::*;
(
	// Clock and reset
	clk,
	rst,
	// Operating mode strap
	op_mode,
	// AHB-Lite slave
	hsel,
	haddr,
	htrans,
	hwrite,
	hsize,
	hwdata,
	hready,
	hreadyout,
	hrdata,
	hresp,
	// Status
	eeprom_map_enable,
	high_voltage_on
);
	input wire logic clk;
	input wire logic rst;
	input wire logic [1:0] op_mode;
	input wire logic hsel;
	input wire logic [31:0] haddr;
	input wire logic [1:0] htrans;
	input wire logic hwrite;
	input wire logic [2:0] hsize;
	input wire logic [31:0] hwdata;
	input wire logic hready;
	output logic hreadyout;
	output logic [31:0] hrdata;
	output logic hresp;
	output logic eeprom_map_enable;
	output logic high_voltage_on;

	function automatic logic is_array(input logic [11:0] a);
		return a[ARRAY_SEL_BIT];
	endfunction

	logic take;
	logic wr_pend_ff;
	logic rd_pend_ff;
	logic [11:0] addr_ff;
	logic hreadyout_ff;
	logic [31:0] hrdata_ff;
	logic hresp_ff;
	logic [4:0] pctl_ff;
	logic hv_prev_ff;
	eep_op_t kind_ff;
	logic tgt_valid_ff;
	logic tgt_cfg_ff;
	logic [8:0] tgt_idx_ff;
	logic [7:0] tgt_data_ff;
	logic op_go_ff;
	logic [7:0] setup_nv_ff;
	logic [7:0] setup_eff_ff;
	logic cap_pending_ff;
	eep_mode_t mode_ff;
	logic map_en_ff;
	logic [4:0] block_protect_register;
	logic [7:0] arr_rd;
	logic wr_hit;
	logic special_mode;
	logic arr_go;

	assign hreadyout = hreadyout_ff;
	assign hrdata = hrdata_ff;
	assign hresp = hresp_ff;
	assign eeprom_map_enable = map_en_ff;
	assign high_voltage_on = pctl_ff[PC_HV];

	assign take = hsel && htrans[1] && hready;
	assign special_mode = mode_ff == MODE_BOOT || mode_ff == MODE_TEST;
	// Array locations only take targets while mapped; the setup register always does.
	assign wr_hit = wr_pend_ff && pctl_ff[PC_LAT] && !pctl_ff[PC_HV]
		&& ((is_array(addr_ff) && map_en_ff) || addr_ff == OFF_SETUP);
	// A setup target only reaches the array when it is a bulk erase.
	assign arr_go = op_go_ff && (!tgt_cfg_ff || kind_ff == OP_BULK);

	// Reads insert one wait state so a write just before is always visible.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			addr_ff <= 12'h000;
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
		end
		else
		begin
			wr_pend_ff <= take && hwrite;
			rd_pend_ff <= take && !hwrite;
			hreadyout_ff <= !(take && !hwrite);
			if (take)
				addr_ff <= haddr[11:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			hrdata_ff <= 32'h0000_0000;
		else if (rd_pend_ff)
		begin
			if (is_array(addr_ff))
				hrdata_ff <= map_en_ff ? {24'h00_0000, arr_rd} : 32'h0000_0000;
			else
			begin
				unique case (addr_ff)
					OFF_PCTL: hrdata_ff <= {27'h000_0000, pctl_ff};
					OFF_BLOCK_PROTECT_REGISTER: hrdata_ff <= {27'h000_0000, block_protect_register};
					OFF_SETUP: hrdata_ff <= {24'h00_0000, setup_eff_ff | SETUP_FIXED};
					OFF_STAT: hrdata_ff <= {27'h000_0000, tgt_valid_ff, mode_ff, map_en_ff, pctl_ff[PC_HV]};
					default: hrdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			pctl_ff <= PCTL_RST;
		else if (wr_pend_ff && addr_ff == OFF_PCTL)
			pctl_ff <= hwdata[4:0];
	end

	// The action kind is held from the high-voltage phase, so clearing the whole
	// register at once still performs the intended action.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			hv_prev_ff <= 1'b0;
			kind_ff <= OP_PROG;
			op_go_ff <= 1'b0;
		end
		else
		begin
			hv_prev_ff <= pctl_ff[PC_HV];
			if (pctl_ff[PC_HV])
				kind_ff <= eep_kind_of(pctl_ff);
			op_go_ff <= hv_prev_ff && !pctl_ff[PC_HV] && tgt_valid_ff;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tgt_valid_ff <= 1'b0;
			tgt_cfg_ff <= 1'b0;
			tgt_idx_ff <= 9'h000;
			tgt_data_ff <= 8'h00;
		end
		else if (!pctl_ff[PC_LAT])
			tgt_valid_ff <= 1'b0;
		else if (wr_hit)
		begin
			tgt_valid_ff <= 1'b1;
			tgt_cfg_ff <= !is_array(addr_ff);
			tgt_idx_ff <= addr_ff[10:2];
			tgt_data_ff <= hwdata[7:0];
		end
	end

	// The stored setup byte is nonvolatile and survives reset.
	always_ff @(posedge clk)
	begin
		if (op_go_ff && tgt_cfg_ff && !block_protect_register[BP_SETUP])
			setup_nv_ff <= (kind_ff == OP_PROG) ? (setup_nv_ff & tgt_data_ff) : ERASED_BYTE;
	end

	// The mode strap and the stored setup byte are sampled once after reset.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cap_pending_ff <= 1'b1;
			mode_ff <= MODE_EXP;
			map_en_ff <= 1'b0;
			setup_eff_ff <= 8'h00;
		end
		else if (cap_pending_ff)
		begin
			cap_pending_ff <= 1'b0;
			mode_ff <= eep_mode_t'(op_mode);
			setup_eff_ff <= setup_nv_ff;
			unique case (eep_mode_t'(op_mode))
				MODE_BOOT, MODE_SINGLE: map_en_ff <= 1'b1;
				MODE_TEST: map_en_ff <= 1'b0;
				MODE_EXP: map_en_ff <= setup_nv_ff[SU_MAP];
			endcase
		end
	end

	eep_protect u_protect (
		.clk(clk),
		.rst(rst),
		.special_mode(special_mode),
		.wr_en(wr_pend_ff && addr_ff == OFF_BLOCK_PROTECT_REGISTER),
		.wdata(hwdata[4:0]),
		.block_protect_register_ff(block_protect_register)
	);

	eep_array u_array (
		.clk(clk),
		.rst(rst),
		.rd_idx(addr_ff[10:2]),
		.rd_data(arr_rd),
		.op_go(arr_go),
		.op_kind(kind_ff),
		.tgt_idx(tgt_idx_ff),
		.tgt_data(tgt_data_ff),
		.prot(block_protect_register[3:0])
	);

	property p_setup_bit1;
		@(posedge clk) disable iff (rst) (rd_pend_ff && addr_ff == OFF_SETUP) |=> hrdata_ff[1];
	endproperty
	a_setup_bit1: assert property (p_setup_bit1) else $error("setup bit 1 read as zero");

	property p_map_forced_on;
		@(posedge clk) disable iff (rst)
			(cap_pending_ff && (op_mode == MODE_BOOT || op_mode == MODE_SINGLE)) |=> map_en_ff;
	endproperty
	a_map_forced_on: assert property (p_map_forced_on) else $error("map enable not forced on");

	property p_map_test_off;
		@(posedge clk) disable iff (rst) (cap_pending_ff && op_mode == MODE_TEST) |=> !map_en_ff;
	endproperty
	a_map_test_off: assert property (p_map_test_off) else $error("map enable not forced off in test");

	property p_unmapped_zero;
		@(posedge clk) disable iff (rst)
			(rd_pend_ff && is_array(addr_ff) && !map_en_ff) |=> hrdata_ff == 32'h0000_0000;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped array answered");

	property p_effective_held;
		@(posedge clk) disable iff (rst) !cap_pending_ff |=> $stable(map_en_ff) && setup_eff_ff === $past(setup_eff_ff);
	endproperty
	a_effective_held: assert property (p_effective_held) else $error("setup took effect before reset");

	property p_no_latch_when_reading;
		@(posedge clk) disable iff (rst) !pctl_ff[PC_LAT] |=> !tgt_valid_ff;
	endproperty
	a_no_latch_when_reading: assert property (p_no_latch_when_reading) else $error("target latched in read mode");

	property p_action_on_drop;
		@(posedge clk) disable iff (rst) op_go_ff |-> $past(hv_prev_ff) && !hv_prev_ff;
	endproperty
	a_action_on_drop: assert property (p_action_on_drop) else $error("action not on voltage drop");

	property p_read_wait;
		@(posedge clk) disable iff (rst) (take && !hwrite) |=> !hreadyout_ff ##1 hreadyout_ff;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

	property p_setup_guard;
		@(posedge clk) disable iff (rst)
			(op_go_ff && tgt_cfg_ff && block_protect_register[BP_SETUP]) |=> setup_nv_ff == $past(setup_nv_ff);
	endproperty
	a_setup_guard: assert property (p_setup_guard) else $error("protected setup changed");

	property p_pctl_written;
		@(posedge clk) disable iff (rst)
			(wr_pend_ff && addr_ff == OFF_PCTL) |=> pctl_ff == $past(hwdata[4:0]);
	endproperty
	a_pctl_written: assert property (p_pctl_written) else $error("control register write lost");

	property p_target_latched;
		@(posedge clk) disable iff (rst)
			wr_hit |=> tgt_valid_ff && tgt_idx_ff == $past(addr_ff[10:2]);
	endproperty
	a_target_latched: assert property (p_target_latched) else $error("target not latched");

	property p_latch_dropped;
		@(posedge clk) disable iff (rst)
			(wr_pend_ff && addr_ff == OFF_PCTL && !hwdata[PC_LAT]) |=> ##1 !tgt_valid_ff;
	endproperty
	a_latch_dropped: assert property (p_latch_dropped) else $error("target kept after latch cleared");

	property p_go_needs_target;
		@(posedge clk) disable iff (rst)
			op_go_ff |-> $past(tgt_valid_ff);
	endproperty
	a_go_needs_target: assert property (p_go_needs_target) else $error("action without a target");

	property p_setup_programmed;
		@(posedge clk) disable iff (rst)
			(op_go_ff && tgt_cfg_ff && !block_protect_register[BP_SETUP] && kind_ff == OP_PROG) |=> setup_nv_ff == ($past(setup_nv_ff) & $past(tgt_data_ff));
	endproperty
	a_setup_programmed: assert property (p_setup_programmed) else $error("setup program wrong");

	property p_setup_erased;
		@(posedge clk) disable iff (rst)
			(op_go_ff && tgt_cfg_ff && !block_protect_register[BP_SETUP] && kind_ff != OP_PROG) |=> setup_nv_ff == ERASED_BYTE;
	endproperty
	a_setup_erased: assert property (p_setup_erased) else $error("setup erase wrong");

	property p_map_expanded;
		@(posedge clk) disable iff (rst)
			(cap_pending_ff && op_mode == MODE_EXP) |=> map_en_ff == $past(setup_nv_ff[SU_MAP]);
	endproperty
	a_map_expanded: assert property (p_map_expanded) else $error("expanded map enable wrong");

	property p_array_read;
		@(posedge clk) disable iff (rst)
			(rd_pend_ff && is_array(addr_ff) && map_en_ff) |=> hrdata_ff == {24'h00_0000, $past(arr_rd)};
	endproperty
	a_array_read: assert property (p_array_read) else $error("mapped array read wrong");
endmodule
`default_nettype wire

//--- verif/eep_cpu.sv
// Processor-side bus master that runs the program and erase procedures.
`timescale 1ns/10ps
`default_nettype none
module eep_cpu
	import eep_pkg::*;
#(
	parameter int HOLD = 8
)
(
	// Clock
	input wire logic clk,
	// AHB-Lite master
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// Called right after a rising edge; write data is inverted when unused so stale values never pass.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		hwdata <= ~hwdata;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= w ? {24'h0, d} : ~hwdata;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		xfer(1'b0, a, 8'h00, q);
	endtask

	// The real hold is 10 ms; HOLD is a shortened stand-in since the device does not time it.
	task automatic op(input logic [4:0] c, input logic [11:0] a, input logic [7:0] d);
		wr(OFF_PCTL, {3'h0, c});
		wr(a, d);
		wr(OFF_PCTL, {3'h0, c | 5'h01});
		repeat (HOLD) @(posedge clk);
		wr(OFF_PCTL, {3'h0, c});
		wr(OFF_PCTL, 8'h00);
	endtask
endmodule
`default_nettype wire

//--- verif/eep_top_test.sv
// Self-checking bench for the EEPROM program and erase controller.
`timescale 1ns/10ps
`default_nettype none
module eep_top_test
	import eep_pkg::*;
;
	logic clk;
	logic rst;
	logic [1:0] op_mode;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	logic map_en;
	logic hv_on;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	logic [31:0] v;
	logic [8:0] idx;
	logic [7:0] d;
	logic [8:0] zl[6] = '{9'h040, 9'h041, 9'h042, 9'h050, 9'h05F, 9'h060};

	eep_top eep_top_inst (.clk(clk), .rst(rst), .op_mode(op_mode), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .eeprom_map_enable(map_en),
		.high_voltage_on(hv_on));
	eep_cpu eep_cpu_inst (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [11:0] aa(input logic [8:0] i);
		return {1'b1, i, 2'b00};
	endfunction

	function automatic logic exp_map(input logic [1:0] m, input logic [7:0] su);
		if (m == MODE_BOOT || m == MODE_SINGLE)
			return 1'b1;
		return (m == MODE_EXP) ? su[SU_MAP] : 1'b0;
	endfunction

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
		eep_cpu_inst.rd(a, v);
		check(what, exp, v);
	endtask

	// The first bus request waits two edges after release, since the first one captures the mode.
	task automatic do_rst(input logic [1:0] m);
		rst <= 1'b1;
		op_mode <= m;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_errors++;
			wrap_up;
		end
	end

	initial
	begin
		rst = 1'b1;
		op_mode = 2'h1;
		v = $urandom(2);
		@(posedge clk);
		do_rst(2'h1);
		check("map single", 32'h1, {31'h0, map_en});
		rdc("pctl reset", OFF_PCTL, {27'h0, PCTL_RST});
		rdc("block_protect_register reset", OFF_BLOCK_PROTECT_REGISTER, {27'h0, BLOCK_PROTECT_REGISTER_RST});
		eep_cpu_inst.wr(OFF_BLOCK_PROTECT_REGISTER, 8'h00);
		rdc("block_protect_register cleared", OFF_BLOCK_PROTECT_REGISTER, 32'h0);
		$display("test reset done");
		eep_cpu_inst.op(5'h06, aa(9'($urandom)), 8'($urandom));
		repeat (8) rdc("bulk", aa(9'($urandom)), {24'h0, ERASED_BYTE});
		$display("test bulk done");
		for (int k = 0; k < 6; k++)
		begin
			// Distinct low bits keep the six targets apart, since programming only clears bits.
			idx = {1'b1, 5'($urandom), 3'(k)};
			d = 8'($urandom);
			eep_cpu_inst.op(5'h02, aa(idx), d);
			rdc("program", aa(idx), {24'h0, d});
		end
		eep_cpu_inst.wr(OFF_PCTL, 8'h02);
		eep_cpu_inst.wr(aa(idx), 8'h00);
		eep_cpu_inst.wr(OFF_PCTL, 8'h03);
		rdc("held during hv", aa(idx), {24'h0, d});
		check("hv pin", 32'h1, {31'h0, hv_on});
		eep_cpu_inst.wr(OFF_PCTL, 8'h02);
		eep_cpu_inst.wr(OFF_PCTL, 8'h00);
		rdc("landed", aa(idx), 32'h0);
		$display("test program done");
		foreach (zl[i]) eep_cpu_inst.op(5'h02, aa(zl[i]), 8'h00);
		eep_cpu_inst.op(5'h16, aa(9'h040), 8'($urandom));
		eep_cpu_inst.op(5'h1E, aa(9'h041), 8'($urandom));
		eep_cpu_inst.op(5'h0E, aa(9'h055), 8'($urandom));
		eep_cpu_inst.wr(aa(9'h050), 8'h00);
		foreach (zl[i]) rdc("erase kinds", aa(zl[i]), (i == 2 || i == 5) ? 32'h0 : {24'h0, ERASED_BYTE});
		$display("test erase kinds done");
		eep_cpu_inst.wr(OFF_BLOCK_PROTECT_REGISTER, 8'h01);
		eep_cpu_inst.wr(OFF_BLOCK_PROTECT_REGISTER, 8'h00);
		rdc("block_protect_register late clear", OFF_BLOCK_PROTECT_REGISTER, 32'h1);
		eep_cpu_inst.op(5'h02, aa(9'h010), 8'h00);
		eep_cpu_inst.op(5'h02, aa(9'h030), 8'h00);
		rdc("protected", aa(9'h010), {24'h0, ERASED_BYTE});
		rdc("open", aa(9'h030), 32'h0);
		$display("test protect done");
		eep_cpu_inst.op(5'h16, OFF_SETUP, 8'($urandom));
		do_rst(2'h3);
		eep_cpu_inst.wr(OFF_BLOCK_PROTECT_REGISTER, 8'h00);
		rdc("setup erased", OFF_SETUP, {24'h0, ERASED_BYTE});
		check("map exp on", 32'h1, {31'h0, map_en});
		eep_cpu_inst.op(5'h02, OFF_SETUP, 8'hF4);
		rdc("setup held", OFF_SETUP, {24'h0, ERASED_BYTE});
		check("map held", 32'h1, {31'h0, map_en});
		do_rst(2'h3);
		rdc("setup new", OFF_SETUP, {24'h0, 8'hF4 | SETUP_FIXED});
		check("map exp off", 32'h0, {31'h0, map_en});
		rdc("unmapped", aa(9'h040), 32'h0);
		$display("test setup done");
		for (int m = 2; m >= 0; m--)
		begin
			do_rst(m[1:0]);
			check("map by mode", {31'h0, exp_map(m[1:0], 8'hF4)}, {31'h0, map_en});
		end
		rdc("mapped again", aa(9'h040), {24'h0, ERASED_BYTE});
		check("response", 32'h0, {31'h0, hresp});
		$display("test modes done");
		wrap_up;
	end
endmodule
`default_nettype wire
